// ---- pkg/watchdog_defines.svh ----
// Constant definitions for the watchdog downcounter
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH

// -------------------------------------------------------------------
// Register map (byte addresses on the register port)
// -------------------------------------------------------------------
`define RELOAD_HIGH_ADDR   8'h42
`define RELOAD_LOW_ADDR    8'h43

// -------------------------------------------------------------------
// Unlock keys
// -------------------------------------------------------------------
`define UNLOCK_KEY_FIRST   8'h55
`define UNLOCK_KEY_SECOND  8'haa

// -------------------------------------------------------------------
// Reset values and counter constants
// -------------------------------------------------------------------
`define RELOAD_RESET       16'h0400
`define COUNT_ZERO         16'h0000
`define COUNT_STEP         16'h0001
`define READ_IDLE          8'h00

// -------------------------------------------------------------------
// Clocks
// -------------------------------------------------------------------
`define REF_CLK_HZ         40000000
`define RC_OSC_TYP_HZ      10000
`define TIMEOUT_MS_DIVISOR 10

`endif

// ---- pkg/watchdog_pkg.sv ----
// Types shared by the watchdog downcounter design
package watchdog_pkg;

  // -----------------------------------------------------------------
  // Unlock sequence states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    UNLOCK_IDLE     = 2'b00,
    UNLOCK_KEY1_OK  = 2'b01,
    UNLOCK_WAIT_HI  = 2'b10,
    UNLOCK_WAIT_LO  = 2'b11
  } unlock_state_t;

  // -----------------------------------------------------------------
  // Time-out response toward interrupt and reset control
  // -----------------------------------------------------------------
  typedef struct packed {
    logic exception_req;
    logic reset_req;
    logic stop_recovery;
    logic status_timeout;
    logic status_stop;
  } timeout_resp_t;

endpackage

// ---- design/sync_level.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module sync_level #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // -----------------------------------------------------------------
  // Stages
  // -----------------------------------------------------------------
  // No reset: the stages settle within two edges and a reset here
  // would itself need a synchroniser
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q   <= async_in;
    sync_out <= meta_q;
  end

endmodule // sync_level

`default_nettype wire

// ---- design/pulse_sync.sv ----
// Toggle-based single-cycle event crossing between two clocks
`timescale 1ns/1ps
`default_nettype none

module pulse_sync (
  input  wire logic src_clk,
  input  wire logic src_rst_n,
  input  wire logic src_pulse,
  input  wire logic dst_clk,
  input  wire logic dst_rst_n,
  output logic      dst_pulse
);

  // -----------------------------------------------------------------
  // Source side toggle
  // -----------------------------------------------------------------
  logic tgl_q;
  logic tgl_d;

  always_comb begin
    tgl_d = tgl_q ^ src_pulse;
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      tgl_q <= 1'b0;
    end else begin
      tgl_q <= tgl_d;
    end
  end

  // -----------------------------------------------------------------
  // Destination side edge detect
  // -----------------------------------------------------------------
  logic tgl_s;
  logic last_q;
  logic pulse_d;

  sync_level #(.WIDTH(1)) u_sync (
    .clk      (dst_clk),
    .async_in (tgl_q),
    .sync_out (tgl_s)
  );

  always_comb begin
    pulse_d = tgl_s ^ last_q;
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      last_q    <= 1'b0;
      dst_pulse <= 1'b0;
    end else begin
      last_q    <= tgl_s;
      dst_pulse <= pulse_d;
    end
  end

endmodule // pulse_sync

`default_nettype wire

// ---- design/watchdog_timer.sv ----
// Watchdog downcounter with RC oscillator domain and unlockable reload
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defines.svh"

// Function
// - Retriggerable one-shot that resets or interrupts on reaching terminal count.
// - Counter runs only on its own RC oscillator clock.
// - Only on or off; once on it stays on until reset.
// - Enabled by refresh instruction or always-on option bit.
// - Oscillator enable cleared stops counting and time-outs.
// - 16-bit down-counter; reload is high byte concatenated with low byte.
// - Time-out in ms equals reload value over ten at 10 kHz.
// - Reload value after reset is 0400, about 102.4 ms.
// - First enable loads counter from reload, then counts toward zero.
// - Each refresh reloads the counter, then counting resumes.
// - Debug mode refreshes the counter continuously, no time-out.
// - Time-out is detected when the counter equals zero.
// - Time-out gives exception or short reset per response select bit.
// - Exception mode, normal: request exception; counter reloads and continues.
// - Exception mode in STOP: recovery, exception, watchdog and STOP status set.
// - Reset mode, normal: force reset, set watchdog status; counter resets.
// - Reset mode in STOP: recovery instead of reset, both status bits set.
// - Reload writes need 55, AA to high address, then high, then low.
// - Reading reload addresses returns bytes of the current count.
module watchdog_timer #(
  parameter int COUNT_W = 16,
  parameter int BYTE_W  = 8
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      rc_clk,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [BYTE_W-1:0]         reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [BYTE_W-1:0]         reg_rdata_q,
  input  wire logic                      refresh_insn,
  input  wire logic                      always_on_option,
  input  wire logic                      rc_osc_enable,
  input  wire logic                      timeout_response_select,
  input  wire logic                      stop_mode,
  input  wire logic                      on_chip_debugger,
  output watchdog_pkg::timeout_resp_t    resp_q
);

  // -----------------------------------------------------------------
  // Parameter check
  // -----------------------------------------------------------------
  if (COUNT_W != 2 * BYTE_W || BYTE_W != 8) begin : g_bad_width
    $error("watchdog_timer: needs BYTE_W of 8 and COUNT_W of 16");
  end

  // -----------------------------------------------------------------
  // RC domain reset
  // -----------------------------------------------------------------
  logic rc_rst_n;

  sync_level #(.WIDTH(1)) u_rc_rst (
    .clk      (rc_clk),
    .async_in (rst_n),
    .sync_out (rc_rst_n)
  );

  // -----------------------------------------------------------------
  // Unlock sequence and reload registers (system clock)
  // -----------------------------------------------------------------
  watchdog_pkg::unlock_state_t ulk_q;
  watchdog_pkg::unlock_state_t ulk_d;
  logic [BYTE_W-1:0]           rel_hi_q;
  logic [BYTE_W-1:0]           rel_hi_d;
  logic [BYTE_W-1:0]           rel_lo_q;
  logic [BYTE_W-1:0]           rel_lo_d;
  logic                        rel_dirty_q;
  logic                        rel_dirty_d;
  logic                        wr_hi;
  logic                        wr_lo;
  logic                        rel_send;

  always_comb begin
    wr_hi       = reg_wr && (reg_addr == `RELOAD_HIGH_ADDR);
    wr_lo       = reg_wr && (reg_addr == `RELOAD_LOW_ADDR);
    ulk_d       = ulk_q;
    rel_hi_d    = rel_hi_q;
    rel_lo_d    = rel_lo_q;
    // A low byte landing in the send cycle must win over the clear
    rel_dirty_d = rel_dirty_q && !rel_send;
    // Key writes never touch the stored bits
    unique case (ulk_q)
      watchdog_pkg::UNLOCK_IDLE: begin
        if (wr_hi && reg_wdata == `UNLOCK_KEY_FIRST) begin
          ulk_d = watchdog_pkg::UNLOCK_KEY1_OK;
        end
      end
      watchdog_pkg::UNLOCK_KEY1_OK: begin
        if (wr_hi && reg_wdata == `UNLOCK_KEY_SECOND) begin
          ulk_d = watchdog_pkg::UNLOCK_WAIT_HI;
        end else if (reg_wr) begin
          ulk_d = watchdog_pkg::UNLOCK_IDLE;
        end
      end
      watchdog_pkg::UNLOCK_WAIT_HI: begin
        if (wr_hi) begin
          rel_hi_d = reg_wdata;
          ulk_d    = watchdog_pkg::UNLOCK_WAIT_LO;
        end else if (reg_wr) begin
          ulk_d = watchdog_pkg::UNLOCK_IDLE;
        end
      end
      watchdog_pkg::UNLOCK_WAIT_LO: begin
        if (wr_lo) begin
          rel_lo_d    = reg_wdata;
          rel_dirty_d = 1'b1;
          ulk_d       = watchdog_pkg::UNLOCK_IDLE;
        end else if (reg_wr) begin
          ulk_d = watchdog_pkg::UNLOCK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ulk_q       <= watchdog_pkg::UNLOCK_IDLE;
      rel_hi_q    <= BYTE_W'(`RELOAD_RESET >> BYTE_W);
      rel_lo_q    <= BYTE_W'(`RELOAD_RESET);
      rel_dirty_q <= 1'b0;
    end else begin
      ulk_q       <= ulk_d;
      rel_hi_q    <= rel_hi_d;
      rel_lo_q    <= rel_lo_d;
      rel_dirty_q <= rel_dirty_d;
    end
  end

  // -----------------------------------------------------------------
  // Reload word handshake to RC domain
  // -----------------------------------------------------------------
  // The word is held still until the RC side acknowledges, so a later
  // unlock sequence waits in the dirty flag instead of tearing it
  logic [COUNT_W-1:0] rel_xfer_q;
  logic [COUNT_W-1:0] rel_xfer_d;
  logic               rel_req_q;
  logic               rel_req_d;
  logic               rel_ack_s;

  always_comb begin
    rel_send   = rel_dirty_q && (rel_req_q == rel_ack_s);
    rel_xfer_d = rel_xfer_q;
    rel_req_d  = rel_req_q;
    if (rel_send) begin
      rel_xfer_d = {rel_hi_q, rel_lo_q};
      rel_req_d  = ~rel_req_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rel_xfer_q <= `RELOAD_RESET;
      rel_req_q  <= 1'b0;
    end else begin
      rel_xfer_q <= rel_xfer_d;
      rel_req_q  <= rel_req_d;
    end
  end

  // -----------------------------------------------------------------
  // Enable and refresh (system clock)
  // -----------------------------------------------------------------
  logic enabled_q;
  logic enabled_d;

  always_comb begin
    // Sticky: there is no way back to off short of reset
    enabled_d = enabled_q || refresh_insn || always_on_option;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enabled_q <= 1'b0;
    end else begin
      enabled_q <= enabled_d;
    end
  end

  logic rc_refresh;

  pulse_sync u_refresh (
    .src_clk   (ref_clk),
    .src_rst_n (rst_n),
    .src_pulse (refresh_insn),
    .dst_clk   (rc_clk),
    .dst_rst_n (rc_rst_n),
    .dst_pulse (rc_refresh)
  );

  // Levels into the RC domain
  logic [3:0] rc_lvl_s;

  sync_level #(.WIDTH(4)) u_rc_lvl (
    .clk      (rc_clk),
    .async_in ({enabled_q, rc_osc_enable, on_chip_debugger, rel_req_q}),
    .sync_out (rc_lvl_s)
  );

  // -----------------------------------------------------------------
  // Downcounter (RC oscillator clock)
  // -----------------------------------------------------------------
  logic [COUNT_W-1:0] cnt_q;
  logic [COUNT_W-1:0] cnt_d;
  logic [COUNT_W-1:0] rc_rel_q;
  logic [COUNT_W-1:0] rc_rel_d;
  logic               running_q;
  logic               running_d;
  logic               rc_ack_q;
  logic               rc_ack_d;
  logic               rc_tmo_q;
  logic               rc_tmo_d;

  always_comb begin
    cnt_d     = cnt_q;
    rc_rel_d  = rc_rel_q;
    running_d = running_q;
    rc_ack_d  = rc_ack_q;
    rc_tmo_d  = 1'b0;
    if (rc_lvl_s[0] != rc_ack_q) begin
      rc_rel_d = rel_xfer_q;
      rc_ack_d = rc_lvl_s[0];
    end
    // A cleared oscillator enable freezes the count and time-outs; reload capture still runs
    if (rc_lvl_s[2]) begin
      running_d = rc_lvl_s[3];
      if (rc_lvl_s[3] && (rc_lvl_s[1] || rc_refresh || !running_q)) begin
        cnt_d = rc_rel_q;
      end else if (running_q) begin
        if (cnt_q == `COUNT_ZERO) begin
          rc_tmo_d = 1'b1;
          cnt_d    = rc_rel_q;
        end else begin
          cnt_d = cnt_q - `COUNT_STEP;
        end
      end
    end
  end

  always_ff @(posedge rc_clk) begin
    if (!rc_rst_n) begin
      cnt_q     <= `RELOAD_RESET;
      rc_rel_q  <= `RELOAD_RESET;
      running_q <= 1'b0;
      rc_ack_q  <= 1'b0;
      rc_tmo_q  <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      rc_rel_q  <= rc_rel_d;
      running_q <= running_d;
      rc_ack_q  <= rc_ack_d;
      rc_tmo_q  <= rc_tmo_d;
    end
  end

  sync_level #(.WIDTH(1)) u_ack (
    .clk      (ref_clk),
    .async_in (rc_ack_q),
    .sync_out (rel_ack_s)
  );

  // -----------------------------------------------------------------
  // Count snapshot handshake back to system clock
  // -----------------------------------------------------------------
  logic [COUNT_W-1:0] snap_q;
  logic [COUNT_W-1:0] snap_d;
  logic               snap_req_q;
  logic               snap_req_d;
  logic               snap_ack_s;

  always_comb begin
    snap_d     = snap_q;
    snap_req_d = snap_req_q;
    if (snap_req_q == snap_ack_s) begin
      snap_d     = cnt_q;
      snap_req_d = ~snap_req_q;
    end
  end

  always_ff @(posedge rc_clk) begin
    if (!rc_rst_n) begin
      snap_q     <= `RELOAD_RESET;
      snap_req_q <= 1'b0;
    end else begin
      snap_q     <= snap_d;
      snap_req_q <= snap_req_d;
    end
  end

  logic               snap_req_s;
  logic               view_ack_q;
  logic               view_ack_d;
  logic [COUNT_W-1:0] view_q;
  logic [COUNT_W-1:0] view_d;

  sync_level #(.WIDTH(1)) u_snap_req (
    .clk      (ref_clk),
    .async_in (snap_req_q),
    .sync_out (snap_req_s)
  );

  sync_level #(.WIDTH(1)) u_snap_ack (
    .clk      (rc_clk),
    .async_in (view_ack_q),
    .sync_out (snap_ack_s)
  );

  always_comb begin
    view_d     = view_q;
    view_ack_d = view_ack_q;
    if (snap_req_s != view_ack_q) begin
      view_d     = snap_q;
      view_ack_d = snap_req_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      view_q     <= `RELOAD_RESET;
      view_ack_q <= 1'b0;
    end else begin
      view_q     <= view_d;
      view_ack_q <= view_ack_d;
    end
  end

  // -----------------------------------------------------------------
  // Register read port
  // -----------------------------------------------------------------
  logic [BYTE_W-1:0] rdata_d;

  always_comb begin
    rdata_d = `READ_IDLE;
    if (reg_rd && reg_addr == `RELOAD_HIGH_ADDR) begin
      rdata_d = view_q[COUNT_W-1:BYTE_W];
    end else if (reg_rd && reg_addr == `RELOAD_LOW_ADDR) begin
      rdata_d = view_q[BYTE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= `READ_IDLE;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  // -----------------------------------------------------------------
  // Time-out response (system clock)
  // -----------------------------------------------------------------
  // Stop mode is judged on the system side when the event arrives,
  // so a change of stop mode during the crossing uses the late value
  logic                       tmo_evt;
  watchdog_pkg::timeout_resp_t resp_d;

  pulse_sync u_timeout (
    .src_clk   (rc_clk),
    .src_rst_n (rc_rst_n),
    .src_pulse (rc_tmo_q),
    .dst_clk   (ref_clk),
    .dst_rst_n (rst_n),
    .dst_pulse (tmo_evt)
  );

  always_comb begin
    resp_d = '0;
    if (tmo_evt) begin
      resp_d.status_timeout = 1'b1;
      if (stop_mode) begin
        resp_d.stop_recovery = 1'b1;
        resp_d.status_stop   = 1'b1;
        resp_d.exception_req = !timeout_response_select;
      end else if (timeout_response_select) begin
        resp_d.reset_req = 1'b1;
      end else begin
        resp_d.exception_req  = 1'b1;
        resp_d.status_timeout = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resp_q <= '0;
    end else begin
      resp_q <= resp_d;
    end
  end

endmodule // watchdog_timer

`default_nettype wire

// ---- verification/watchdog_monitor.sv ----
// Concurrent checks on the watchdog register port and time-out responses
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defines.svh"

module watchdog_monitor #(
  parameter int COUNT_W = 16,
  parameter int BYTE_W  = 8
) (
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  input wire logic                        rc_clk,
  input wire logic [7:0]                  reg_addr,
  input wire logic                        reg_rd,
  input wire logic [BYTE_W-1:0]           reg_rdata_q,
  input wire logic                        refresh_insn,
  input wire logic                        always_on_option,
  input wire logic                        rc_osc_enable,
  input wire logic                        timeout_response_select,
  input wire logic                        stop_mode,
  input wire logic                        on_chip_debugger,
  input wire watchdog_pkg::timeout_resp_t resp_q
);
  // ---------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------
  // Quiet checks wait 64 cycles so an event already in flight lands
  logic       en_seen_q, en_seen_d;
  logic [6:0] dbg_cnt_q, dbg_cnt_d, off_cnt_q, off_cnt_d;
  always_comb begin
    en_seen_d = en_seen_q | refresh_insn | always_on_option;
    dbg_cnt_d = !on_chip_debugger ? 7'h00 :
                (dbg_cnt_q == 7'h40) ? dbg_cnt_q : dbg_cnt_q + 7'h01;
    off_cnt_d = rc_osc_enable ? 7'h00 :
                (off_cnt_q == 7'h40) ? off_cnt_q : off_cnt_q + 7'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_seen_q <= 1'b0;
      dbg_cnt_q <= 7'h00;
      off_cnt_q <= 7'h00;
    end else begin
      en_seen_q <= en_seen_d;
      dbg_cnt_q <= dbg_cnt_d;
      off_cnt_q <= off_cnt_d;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == `READ_IDLE)
    else $error("read data outside a read answer cycle");
  a_unmapped_rd: assert property ($past(reg_rd) &&
    $past(reg_addr) != `RELOAD_HIGH_ADDR && $past(reg_addr) != `RELOAD_LOW_ADDR
    |-> reg_rdata_q == `READ_IDLE) else $error("unmapped read not zero");
  a_one_pulse: assert property (resp_q != 5'h00 |=> resp_q == 5'h00)
    else $error("response held longer than one cycle");
  // Responses are registered, so they follow the mode inputs one cycle back
  a_exc_select: assert property (resp_q.exception_req |->
    !$past(timeout_response_select)) else $error("exception in reset mode");
  a_rst_select: assert property (resp_q.reset_req |->
    $past(timeout_response_select) && !$past(stop_mode))
    else $error("reset misrouted");
  a_stop_set: assert property (resp_q.stop_recovery |->
    $past(stop_mode) && resp_q.status_stop && resp_q.status_timeout)
    else $error("stop bits wrong");
  a_norm_exc: assert property (resp_q.exception_req &&
    !$past(stop_mode) |-> resp_q == 5'h10)
    else $error("normal exception carries extra bits");
  a_rst_status: assert property (resp_q.reset_req |-> resp_q == 5'h0a)
    else $error("reset response bits wrong");
  a_dbg_quiet: assert property (dbg_cnt_q == 7'h40 |-> resp_q == 5'h00)
    else $error("time-out during debug");
  a_osc_quiet: assert property (off_cnt_q == 7'h40 |-> resp_q == 5'h00)
    else $error("time-out with oscillator off");
  a_needs_en: assert property (resp_q != 5'h00 |-> en_seen_q)
    else $error("time-out before enable");
  c_exc: cover property (resp_q.exception_req && !stop_mode);
  c_rst: cover property (resp_q.reset_req);
  c_stop: cover property (resp_q.stop_recovery);
endmodule // watchdog_monitor

bind watchdog_timer watchdog_monitor #(.COUNT_W(COUNT_W), .BYTE_W(BYTE_W))
  u_watchdog_monitor (.ref_clk, .rst_n, .rc_clk, .reg_addr, .reg_rd,
  .reg_rdata_q, .refresh_insn, .always_on_option, .rc_osc_enable,
  .timeout_response_select, .stop_mode, .on_chip_debugger, .resp_q);
`default_nettype wire

// ---- verification/sys_side_model.sv ----
// Far-side model: RC oscillator cell and reset controller
`timescale 1ns/1ps
`default_nettype none

module sys_side_model #(
  parameter int HALF_NS = 20
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        rc_osc_enable,
  input  wire watchdog_pkg::timeout_resp_t resp_q,
  output logic                             rc_clk,
  output logic                             rst_demand
);
  // Own phase, unrelated to ref_clk; stands still while disabled
  initial begin
    rc_clk = 1'b0;
    #7;
    forever begin
      #HALF_NS;
      if (rc_osc_enable) begin
        rc_clk = ~rc_clk;
      end
    end
  end
  // Demand is held until the system reset actually arrives
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_demand <= 1'b0;
    end else if (resp_q.reset_req) begin
      rst_demand <= 1'b1;
    end
  end
endmodule // sys_side_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the watchdog downcounter
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defines.svh"

module tb_top;
  localparam int RC_NS = 40;
  logic                        ref_clk, rst_n, rc_clk, rst_demand;
  logic [7:0]                  reg_addr, reg_wdata, reg_rdata_q, d;
  logic                        reg_wr, reg_rd, refresh_insn, always_on_option;
  logic                        rc_osc_enable, timeout_response_select;
  logic                        stop_mode, on_chip_debugger;
  watchdog_pkg::timeout_resp_t resp_q, r;
  int                          n_mismatch, checks, cyc, t0, t1;
  logic [1:0]                  md [3] = '{2'b10, 2'b11, 2'b01};
  logic [15:0]                 md_want [3] = '{16'h0017, 16'h0007, 16'h000a};

  watchdog_timer u_watchdog_timer (.ref_clk, .rst_n, .rc_clk, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .refresh_insn,
    .always_on_option, .rc_osc_enable, .timeout_response_select,
    .stop_mode, .on_chip_debugger, .resp_q);
  sys_side_model #(.HALF_NS(RC_NS / 2)) u_sys_side_model (.ref_clk, .rst_n,
    .rc_osc_enable, .resp_q, .rc_clk, .rst_demand);

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic rst_cycle;
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_q;
  endtask
  task automatic unlock(input logic [7:0] hi, input logic [7:0] lo);
    wr(`RELOAD_HIGH_ADDR, `UNLOCK_KEY_FIRST);
    wr(`RELOAD_HIGH_ADDR, `UNLOCK_KEY_SECOND);
    wr(`RELOAD_HIGH_ADDR, hi);
    wr(`RELOAD_LOW_ADDR, lo);
  endtask
  task automatic pulse_refresh;
    @(posedge ref_clk);
    refresh_insn <= 1'b1;
    @(posedge ref_clk);
    refresh_insn <= 1'b0;
  endtask
  // All bits of one time-out land in one cycle; three more cycles are gathered after it
  task automatic wait_evt(input int lim, output int t);
    r = 5'h00;
    for (int i = 0; i < lim && r === 5'h00; i++) begin
      @(posedge ref_clk);
      #1 r = resp_q;
    end
    t = cyc;
    if (r === 5'h00) begin
      check("event arrived", 16'h0000, 16'h0001);
      give_verdict();
    end
    repeat (3) begin
      @(posedge ref_clk);
      #1 r = r | resp_q;
    end
  endtask
  task automatic quiet(input int n);
    logic [4:0] acc;
    acc = 5'h00;
    repeat (n) begin
      @(posedge ref_clk);
      #1 acc = acc | resp_q;
    end
    check("quiet resp", 16'(acc), 16'h0000);
  endtask
  // Sync jitter on both edges of the interval allows three cycles slack
  task automatic period(input logic [15:0] rl);
    int want;
    want = (int'(rl) + 1) * RC_NS / 25;
    wait_evt(2 * want + 50, t0);
    wait_evt(want + 50, t1);
    check("period", 16'(t1 - t0 >= want - 3 && t1 - t0 <= want + 3), 16'h0001);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, refresh_insn} = 19'h00000;
    {always_on_option, timeout_response_select, stop_mode} = 3'h0;
    on_chip_debugger = 1'b0;
    rc_osc_enable = 1'b1;
    n_mismatch = 0;
    checks = 0;
    cyc = 0;
    rst_cycle();
    rd(`RELOAD_HIGH_ADDR, d);
    check("count hi", 16'(d), 16'h0004);
    rd(`RELOAD_LOW_ADDR, d);
    check("count lo", 16'(d), 16'h0000);
    rd(8'h44, d);
    check("unmapped", 16'(d), 16'h0000);
    quiet(400);
    // Aborted unlock, then keys without a fresh first key: all ignored
    wr(`RELOAD_HIGH_ADDR, `UNLOCK_KEY_FIRST);
    wr(`RELOAD_LOW_ADDR, 8'h12);
    wr(`RELOAD_HIGH_ADDR, `UNLOCK_KEY_SECOND);
    wr(`RELOAD_HIGH_ADDR, 8'h00);
    wr(`RELOAD_LOW_ADDR, 8'h10);
    pulse_refresh();
    period(16'h0400);
    check("exc normal", 16'(r), 16'h0010);
    unlock(8'h00, 8'h10);
    repeat (20) @(posedge ref_clk);
    pulse_refresh();
    period(16'h0010);
    fork
      quiet(340);
      repeat (20) begin
        pulse_refresh();
        repeat (15) @(posedge ref_clk);
      end
    join
    wait_evt(80, t0);
    rd(`RELOAD_HIGH_ADDR, d);
    check("run hi", 16'(d), 16'h0000);
    rd(`RELOAD_LOW_ADDR, d);
    check("run lo in range", 16'(d <= 8'h10), 16'h0001);
    wait_evt(80, t0);
    @(posedge ref_clk) on_chip_debugger <= 1'b1;
    quiet(300);
    @(posedge ref_clk) on_chip_debugger <= 1'b0;
    wait_evt(100, t0);
    @(posedge ref_clk) rc_osc_enable <= 1'b0;
    quiet(300);
    @(posedge ref_clk) rc_osc_enable <= 1'b1;
    wait_evt(100, t0);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk) {stop_mode, timeout_response_select} <= md[i];
      wait_evt(80, t0);
      check("mode resp", 16'(r), md_want[i]);
    end
    check("reset demand", 16'(rst_demand), 16'h0001);
    @(posedge ref_clk) {stop_mode, timeout_response_select} <= 2'b00;
    rst_cycle();
    rd(`RELOAD_HIGH_ADDR, d);
    check("count after reset", 16'(d), 16'h0004);
    @(posedge ref_clk) always_on_option <= 1'b1;
    wait_evt(1800, t0);
    check("always on exc", 16'(r), 16'h0010);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
